// >>> iowd_consts.vh
// register offsets, field positions and reset values for the io window decoder
`ifndef IOWD_CONSTS_VH
`define IOWD_CONSTS_VH

`define IOWD_IDX_MAP_ENABLE   8'h06
`define IOWD_IDX_WIN_CTRL     8'h07
`define IOWD_IDX_W0_START_LO  8'h08
`define IOWD_IDX_W0_START_HI  8'h09
`define IOWD_IDX_W0_END_LO    8'h0A
`define IOWD_IDX_W0_END_HI    8'h0B
`define IOWD_IDX_W1_START_LO  8'h0C
`define IOWD_IDX_W1_START_HI  8'h0D
`define IOWD_IDX_W1_END_LO    8'h0E
`define IOWD_IDX_W1_END_HI    8'h0F
`define IOWD_IDX_DECODE_STAT  8'h10

`define IOWD_BIT_W0_SIZE      0
`define IOWD_BIT_W0_AUTO      1
`define IOWD_BIT_W0_TIMING    3
`define IOWD_BIT_W1_SIZE      4
`define IOWD_BIT_W1_AUTO      5
`define IOWD_BIT_W1_TIMING    7
`define IOWD_BIT_W0_ENABLE    6
`define IOWD_BIT_W1_ENABLE    7

`define IOWD_RESET_BYTE       8'h00
`define IOWD_NUM_WIN          2
`define IOWD_IDX_W            8
`define IOWD_HRESP_OKAY       1'b0

`endif

// >>> iowd_window_cmp.v
// inclusive range compare for one io window
`timescale 1ns/1ps
`default_nettype none
module iowd_window_cmp (
  input  wire [15:0] hostAddr,
  input  wire [15:0] startAddr,
  input  wire [15:0] endAddr,
  input  wire        enable,
  output wire        hit
);
  assign hit = enable && (hostAddr >= startAddr) && (hostAddr <= endAddr);
endmodule
`default_nettype wire

// >>> iowd_reg_file.v
// sixteen-entry byte register file, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "iowd_consts.vh"
module iowd_reg_file (
  input  wire         core_clk,
  input  wire         rst,
  input  wire         clkEn,
  input  wire         wrEn,
  input  wire [3:0]   wrIdx,
  input  wire [7:0]   wrData,
  input  wire [3:0]   rdIdx,
  output reg  [7:0]   rdData_ff,
  output wire [127:0] allRegs
);
  reg [7:0] mem_ff [0:15];
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gEntry
      always @(posedge core_clk) begin
        if (rst) begin
          mem_ff[g] <= `IOWD_RESET_BYTE;
        end else if (clkEn && wrEn && (wrIdx == g)) begin
          mem_ff[g] <= wrData;
        end
      end
      assign allRegs[g*8 +: 8] = mem_ff[g];
    end
  endgenerate
  always @(posedge core_clk) begin
    if (rst) begin
      rdData_ff <= `IOWD_RESET_BYTE;
    end else if (clkEn) begin
      rdData_ff <= mem_ff[rdIdx];
    end
  end
endmodule
`default_nettype wire

// >>> iowd_io_window_decode.v
// per-socket io window decoder with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "iowd_consts.vh"
// Operation
// - Window 1 claims host io cycles in its range only while its mapping enable bit 7 is 1.
// - With auto-size off, control bit 0 picks an 8-bit (0) or 16-bit (1) path for window 0.
// - With control bit 1 set, window 0 width follows the card's 16-bit io indicator and bit 0 is ignored.
// - Control bit 3 picks timing set 0 or 1 for window 0 cycles.
// - With auto-size off, control bit 4 picks an 8-bit (0) or 16-bit (1) path for window 1.
// - With control bit 5 set, window 1 width follows the card's 16-bit io indicator and bit 4 is ignored.
// - Control bit 7 picks timing set 0 or 1 for window 1 cycles.
// - Start low bytes sit at index 08h and 0Ch, read/write, reset to zero.
// - Start high bytes sit at 09h and 0Dh and form bits 15:8 of the start.
// - An access maps to the card only when start <= address <= end, both inclusive.
// - End low bytes sit at 0Ah and 0Eh, read/write.
// - Control, start and end registers exist per socket and every control bit resets to 0.
// - End high bytes sit at 0Bh and 0Fh and form bits 15:8 of the end.
// - Window 0 claims host io cycles in its range only while its mapping enable bit 6 is 1.
module iowd_io_window_decode (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        clkEn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [15:0] hostIoAddr,
  input  wire        hostIoCycle,
  input  wire        card_io_wide_indicator_n,
  output reg         cardIoSelect_ff,
  output reg         cardIoWindow_ff,
  output reg         cardIoWide_ff,
  output reg         cardIoTimingSet_ff
);
  // address phase capture
  reg        wrPend_ff;
  reg        rdPend_ff;
  reg [7:0]  idx_ff;
  reg [7:0]  decodeStat_ff;
  wire       addrPhase;
  wire [7:0] curIdx;
  wire       idxMapped;
  wire       inFile;
  wire [7:0] fileRd;
  wire [127:0] regs;
  wire [7:0] mapEnable;
  wire [7:0] winCtrl;
  wire [15:0] w0Start;
  wire [15:0] w0End;
  wire [15:0] w1Start;
  wire [15:0] w1End;
  wire       hit0;
  wire       hit1;
  wire       cardWide;
  reg        nxt_sel;
  reg        nxt_win;
  reg        nxt_wide;
  reg        nxt_timing;

  assign addrPhase = hsel && hready && htrans[1];
  assign curIdx    = haddr[9:2];
  assign inFile    = (idx_ff[7:4] == 4'h0);
  assign idxMapped = inFile || (idx_ff == `IOWD_IDX_DECODE_STAT);

  always @(posedge core_clk) begin
    if (rst) begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      idx_ff    <= 8'h00;
    end else if (clkEn) begin
      wrPend_ff <= addrPhase && hwrite;
      rdPend_ff <= addrPhase && !hwrite;
      if (addrPhase) begin
        idx_ff <= curIdx;
      end
    end
  end

  // byte registers; only indices 06h..0Fh and status 10h are decoded, others read zero
  iowd_reg_file uRegs (
    .core_clk  (core_clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .wrEn      (wrPend_ff && inFile && (idx_ff[3:0] >= 4'h6)),
    .wrIdx     (idx_ff[3:0]),
    .wrData    (hwdata[7:0]),
    .rdIdx     (curIdx[3:0]),
    .rdData_ff (fileRd),
    .allRegs   (regs)
  );

  assign mapEnable = regs[`IOWD_IDX_MAP_ENABLE*8 +: 8];
  assign winCtrl   = regs[`IOWD_IDX_WIN_CTRL*8 +: 8];
  assign w0Start   = {regs[`IOWD_IDX_W0_START_HI*8 +: 8], regs[`IOWD_IDX_W0_START_LO*8 +: 8]};
  assign w0End     = {regs[`IOWD_IDX_W0_END_HI*8 +: 8], regs[`IOWD_IDX_W0_END_LO*8 +: 8]};
  assign w1Start   = {regs[`IOWD_IDX_W1_START_HI*8 +: 8], regs[`IOWD_IDX_W1_START_LO*8 +: 8]};
  assign w1End     = {regs[`IOWD_IDX_W1_END_HI*8 +: 8], regs[`IOWD_IDX_W1_END_LO*8 +: 8]};

  // ahb answers in the same data phase cycle; read data come from the file register, or from decodeStat_ff for index 10h
  always @* begin
    hreadyout = 1'b1;
    hresp     = `IOWD_HRESP_OKAY;
    hrdata    = 32'h0000_0000;
    if (rdPend_ff && idxMapped) begin
      if (inFile && idx_ff[3:0] >= 4'h6) begin
        hrdata = {24'h00_0000, fileRd};
      end else if (!inFile) begin
        hrdata = {24'h00_0000, decodeStat_ff};
      end
    end
  end

  iowd_window_cmp uCmp0 (
    .hostAddr  (hostIoAddr),
    .startAddr (w0Start),
    .endAddr   (w0End),
    .enable    (mapEnable[`IOWD_BIT_W0_ENABLE]),
    .hit       (hit0)
  );
  iowd_window_cmp uCmp1 (
    .hostAddr  (hostIoAddr),
    .startAddr (w1Start),
    .endAddr   (w1End),
    .enable    (mapEnable[`IOWD_BIT_W1_ENABLE]),
    .hit       (hit1)
  );

  assign cardWide = !card_io_wide_indicator_n;

  always @* begin
    nxt_sel    = 1'b0;
    nxt_win    = 1'b0;
    nxt_wide   = 1'b0;
    nxt_timing = 1'b0;
    if (hostIoCycle && hit0) begin
      nxt_sel    = 1'b1;
      nxt_win    = 1'b0;
      nxt_wide   = winCtrl[`IOWD_BIT_W0_AUTO] ? cardWide : winCtrl[`IOWD_BIT_W0_SIZE];
      nxt_timing = winCtrl[`IOWD_BIT_W0_TIMING];
    end else if (hostIoCycle && hit1) begin
      nxt_sel    = 1'b1;
      nxt_win    = 1'b1;
      nxt_wide   = winCtrl[`IOWD_BIT_W1_AUTO] ? cardWide : winCtrl[`IOWD_BIT_W1_SIZE];
      nxt_timing = winCtrl[`IOWD_BIT_W1_TIMING];
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      cardIoSelect_ff    <= 1'b0;
      cardIoWindow_ff    <= 1'b0;
      cardIoWide_ff      <= 1'b0;
      cardIoTimingSet_ff <= 1'b0;
      decodeStat_ff      <= 8'h00;
    end else if (clkEn) begin
      cardIoSelect_ff    <= nxt_sel;
      cardIoWindow_ff    <= nxt_win;
      cardIoWide_ff      <= nxt_wide;
      cardIoTimingSet_ff <= nxt_timing;
      decodeStat_ff      <= {4'h0, hit1, hit0, nxt_win, nxt_sel};
    end
  end
endmodule
`default_nettype wire

// >>> iowd_card_model.sv
// card side model driving the active-low 16-bit io indicator
`timescale 1ns/1ps
`default_nettype none
module iowd_card_model (
  input  wire logic hostIoCycle,
  input  wire logic wideReq,
  output wire logic card_io_wide_indicator_n
);
  // asserted only inside a host io cycle, released high otherwise
  assign card_io_wide_indicator_n = !(hostIoCycle && wideReq);
endmodule
`default_nettype wire

// >>> iowd_io_window_decode_monitor.sv
// port assertions for the io window decoder
`timescale 1ns/1ps
`default_nettype none
module iowd_decode_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        hostIoCycle,
  input wire logic        cardIoSelect_ff,
  input wire logic        cardIoWindow_ff,
  input wire logic        cardIoWide_ff,
  input wire logic        cardIoTimingSet_ff
);
  wire logic rdReq;
  assign rdReq = hsel && hready && htrans[1] && !hwrite && clkEn;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_ready_always: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("hrdata upper bits set");
  chk_hrdata_idle: assert property (!$past(rdReq) |-> hrdata == 32'h0) else $error("hrdata outside read");
  chk_idle_no_select: assert property ($past(clkEn) && !$past(hostIoCycle) |-> !cardIoSelect_ff)
    else $error("select without io cycle");
  chk_refused_zero: assert property (!cardIoSelect_ff |-> !cardIoWindow_ff && !cardIoWide_ff && !cardIoTimingSet_ff)
    else $error("outputs set without select");
  chk_freeze_hold: assert property (!$past(clkEn) |-> $stable(cardIoSelect_ff) && $stable(cardIoWindow_ff))
    else $error("decode moved while frozen");
  chk_reset_clear: assert property ($past(rst) |-> !cardIoSelect_ff && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// >>> iowd_io_window_decode_bench.sv
// self-checking bench for the io window decoder
`timescale 1ns/1ps
`default_nettype none
module iowd_io_window_decode_bench;
  logic        core_clk = 0, rst = 1, clkEn = 1, hsel = 0, hwrite = 0, hostIoCycle = 0, wideReq = 0;
  logic [31:0] haddr = 0, hwdata = 0, rdSeen;
  logic [1:0]  htrans = 0;
  logic [15:0] hostIoAddr = 0;
  wire logic [31:0] hrdata;
  wire logic   hrdy, indN, hresp, sel, win, wide, tim;
  int          fails = 0, check_count = 0, cyc = 0;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) rdSeen <= hrdata;
  always @(posedge core_clk) if (++cyc > 4000) begin
    fails++;
    report_and_stop;
  end
  iowd_io_window_decode u_dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .hostIoAddr(hostIoAddr), .hostIoCycle(hostIoCycle),
    .card_io_wide_indicator_n(indN), .cardIoSelect_ff(sel), .cardIoWindow_ff(win), .cardIoWide_ff(wide),
    .cardIoTimingSet_ff(tim));
  iowd_card_model u_card (.hostIoCycle(hostIoCycle), .wideReq(wideReq), .card_io_wide_indicator_n(indN));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [31:0] exp);
    hsel <= 1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge core_clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hsel <= 0;
    hwdata <= wd;
    do @(posedge core_clk); while (hrdy !== 1'b1);
    #1 if (!wr) check($sformatf("reg %h", idx), rdSeen, exp);
  endtask
  task automatic io(input logic [15:0] a, input logic w, input logic [3:0] exp);
    hostIoAddr <= a;
    hostIoCycle <= 1;
    wideReq <= w;
    @(posedge core_clk);
    #1 check($sformatf("decode %h", a), {28'h0, sel, win, wide, tim}, {28'h0, exp});
  endtask
  task automatic t_regs;
    for (int i = 6; i < 16; i++) bus(0, 8'(i), 0, 0);
    for (int i = 6; i < 16; i++) bus(1, 8'(i), 32'h5A ^ i, 0);
    for (int i = 6; i < 16; i++) bus(0, 8'(i), 0, 32'h5A ^ i);
    bus(1, 8'h20, 32'hFF, 0);
    bus(0, 8'h20, 0, 0);
    bus(1, 8'h05, 32'hA5, 0);
    bus(0, 8'h05, 0, 0);
  endtask
  task automatic t_decode;
    // both windows stay clear of 3E0h and 3E1h
    bus(1, 8'h06, 0, 0);
    bus(1, 8'h07, 0, 0);
    bus(1, 8'h08, 32'h34, 0);
    bus(1, 8'h09, 32'h12, 0);
    bus(1, 8'h0A, 32'h40, 0);
    bus(1, 8'h0B, 32'h12, 0);
    bus(1, 8'h0C, 32'h38, 0);
    bus(1, 8'h0D, 32'h12, 0);
    bus(1, 8'h0E, 32'h00, 0);
    bus(1, 8'h0F, 32'h20, 0);
    io(16'h1236, 0, 4'b0000);
    bus(1, 8'h06, 32'hC0, 0);
    io(16'h1233, 0, 4'b0000);
    io(16'h1234, 0, 4'b1000);
    io(16'h1240, 0, 4'b1000);
    bus(0, 8'h10, 0, 32'h0D);
    io(16'h1241, 0, 4'b1100);
    io(16'h2000, 0, 4'b1100);
    io(16'h2001, 0, 4'b0000);
    bus(1, 8'h07, 32'h89, 0);
    io(16'h1234, 1, 4'b1011);
    io(16'h1241, 1, 4'b1101);
    bus(1, 8'h07, 32'h33, 0);
    io(16'h1234, 0, 4'b1000);
    io(16'h1238, 1, 4'b1010);
    io(16'h1241, 1, 4'b1110);
    io(16'h1241, 0, 4'b1100);
    bus(1, 8'h06, 32'h80, 0);
    io(16'h1238, 0, 4'b1100);
    bus(1, 8'h06, 32'h40, 0);
    io(16'h1241, 0, 4'b0000);
    hostIoCycle <= 0;
  endtask
  task automatic t_freeze_reset;
    // window 0 is still enabled over 1234h..1240h; a frozen clock must not claim it
    clkEn <= 0;
    hostIoAddr <= 16'h1234;
    hostIoCycle <= 1;
    wideReq <= 0;
    repeat (2) @(posedge core_clk);
    #1 check("frozen decode", {28'h0, sel, win, wide, tim}, 32'h0);
    @(posedge core_clk);
    clkEn <= 1;
    io(16'h1234, 0, 4'b1000);
    @(posedge core_clk);
    hostIoCycle <= 0;
    rst <= 1;
    @(posedge core_clk);
    rst <= 0;
    bus(0, 8'h07, 0, 0);
    bus(0, 8'h0C, 0, 0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 0;
    t_regs;
    t_decode;
    t_freeze_reset;
    report_and_stop;
  end
endmodule
bind iowd_io_window_decode iowd_decode_checker u_chk (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .hostIoCycle(hostIoCycle), .cardIoSelect_ff(cardIoSelect_ff), .cardIoWindow_ff(cardIoWindow_ff),
  .cardIoWide_ff(cardIoWide_ff), .cardIoTimingSet_ff(cardIoTimingSet_ff));
`default_nettype wire
